// [bench/eps_switch_model.sv]
// Power switch driver model on the four PWM pins
`timescale 1ns/100ps
`default_nettype none
module eps_switch_model (
  // Pin drive from the channel
  input  wire logic [3:0] pwm_out,
  input  wire logic [3:0] pwm_oe,
  // Level seen at each switch gate
  output logic      [3:0] gate_level
);
  // Released pins fall to the gate pull-down, keeping switches off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate_level[i] = pwm_oe[i] ? pwm_out[i] : 1'b0;
    end
  end
endmodule
`default_nettype wire

// [bench/eps_tb_top.sv]
// Self-checking bench for the shutdown and steering block
`timescale 1ns/100ps
`default_nettype none
module eps_tb_top;
  import eps_pkg::*;
  logic       mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rnd = 8'h13;
  logic       pwm_raw = 1'b0, period_start = 1'b0, cmp1 = 1'b0, cmp2 = 1'b0;
  logic       ext_pin = 1'b1, sync_tick = 1'b0, sync_en = 1'b0, irq;
  logic [3:0] port_out = 4'h0, pwm_out, pwm_oe, steer_active, gate;
  logic [1:0] tb1;
  logic       hold_raw = 1'b0, raw_val = 1'b0;
  int         mdl [8] = '{0, 0, 0, 1, 0, 0, 0, 0};
  int         checked = 0, err_total = 0;
  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  always #10 mclk = ~mclk;
  eps_core i_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_raw(pwm_raw),
    .period_start(period_start), .cmp1_out(cmp1), .cmp2_out(cmp2), .ext_int_pin(ext_pin),
    .sync_tick(sync_tick), .comparator_sync_en(sync_en), .port_out(port_out),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .steer_active(steer_active), .chan1_timebase(tb1),
    .irq(irq));
  eps_switch_model i_sw (.pwm_out(pwm_out), .pwm_oe(pwm_oe), .gate_level(gate));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Random waveform, port latch and period pulses
  always @(posedge mclk) begin
    rnd          <= lfsr(rnd);
    pwm_raw      <= hold_raw ? raw_val : rnd[0];
    port_out     <= rnd[4:1];
    period_start <= (rnd[7:5] == 3'h0);
  end
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    if (a != 3'h5 && a != 3'h7)
      mdl[a] = (a == ADDR_STEER) ? d & STEER_MASK : (a == ADDR_IRQMSK) ? d & 8'h03 : d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    err_total++;
    conclude();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v, tv;
    logic       t;
    int         cnt;
    tv = 8'h13;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd(k[2:0], v);
      chk("reset", v, mdl[k][7:0]);
    end
    $display("done reset");
    for (int k = 0; k < 4; k++) begin
      tv = lfsr(tv);
      wr(ADDR_TMRSEL, {tv[7:2], k[1:0]});
      rd(ADDR_TMRSEL, v);
      chk("tmrsel", v, mdl[0][7:0]);
      chk("chan1", {6'h00, tb1}, (k == 3) ? 8'h00 : k[7:0]);
    end
    $display("done timebase");
    wr(ADDR_STEER, 8'hFF);
    rd(ADDR_STEER, v);
    chk("steer", v, mdl[3][7:0]);
    wr(ADDR_STEER, 8'h0F);
    repeat (8) @(posedge mclk);
    chk("steer_off", {4'h0, steer_active}, 8'h00);
    wr(ADDR_CHCON, 8'h0C);
    repeat (8) @(posedge mclk);
    chk("steer_on", {4'h0, steer_active}, 8'h0F);
    hold_raw <= 1'b1;
    wr(ADDR_CHCON, 8'h0E);
    repeat (8) @(posedge mclk);
    chk("polarity", {4'h0, pwm_out}, 8'h05);
    wr(ADDR_RDLY, 8'h03);
    raw_val <= 1'b1;
    wait (pwm_raw === 1'b1);
    cnt = 0;
    while (pwm_out[0] !== 1'b0 && cnt < 40) begin
      @(posedge mclk);
      #1 cnt++;
    end
    chk("delay", {7'h00, cnt >= 3 * OSC_PER_ICYC - 1 && cnt <= 3 * OSC_PER_ICYC + 2},
        8'h01);
    hold_raw <= 1'b0;
    raw_val  <= 1'b0;
    wr(ADDR_CHCON, 8'h0C);
    $display("done steering");
    wr(ADDR_RDLY, 8'h80);
    wr(ADDR_IRQMSK, 8'h01);
    for (int s = 0; s < 128; s++) begin
      wr(ADDR_ASD, {1'b0, s[2:0], s[6:5], s[6:5]});
      cmp1    <= s[3];
      cmp2    <= s[4];
      ext_pin <= ~s[2] | s[0];
      t = (s[0] & s[3]) | (s[1] & s[4]) | (s[2] & ~s[0]);
      repeat (6) @(posedge mclk);
      #1 chk("irq", {7'h00, irq}, {7'h00, t});
      if (t) chk("safe", {pwm_oe[1:0], gate[1:0]}, {{2{~s[6]}}, {2{~s[6] & s[5]}}});
      rd(ADDR_ASD, v);
      chk("status", v, {t, s[2:0], s[6:5], s[6:5]});
      rd(ADDR_IRQST, v);
      chk("irqst", v & 8'h01, {7'h00, t});
      cmp1    <= 1'b0;
      cmp2    <= 1'b0;
      ext_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(ADDR_ASD, v);
      chk("autorestart", {7'h00, v[7]}, 8'h00);
      rd(ADDR_IRQST, v);
      chk("restart", v & 8'h02, {6'h00, t, 1'b0});
    end
    $display("done sources");
    wr(ADDR_RDLY, 8'h05);
    wr(ADDR_ASD, 8'h10);
    cmp1 <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(ADDR_ASD, 8'h10);
    rd(ADDR_ASD, v);
    chk("hold", v, 8'h90);
    cmp1 <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(ADDR_ASD, v);
    chk("manual", v, 8'h90);
    wr(ADDR_ASD, 8'h10);
    rd(ADDR_ASD, v);
    chk("cleared", v, 8'h10);
    sync_en <= 1'b1;
    cmp1    <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(ADDR_ASD, v);
    chk("nosync", v, 8'h10);
    @(posedge mclk);
    sync_tick <= 1'b1;
    @(posedge mclk);
    sync_tick <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(ADDR_ASD, v);
    chk("synced", v, 8'h90);
    $display("done restart");
    conclude();
  end
endmodule
`default_nettype wire

// [core/eps_core.sv]
// Shutdown, edge delay and output steering logic for one enhanced PWM channel
`timescale 1ns/100ps
`default_nettype none
module eps_core
  import eps_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Waveform and shutdown sources
  input  wire logic       pwm_raw,
  input  wire logic       period_start,
  input  wire logic       cmp1_out,
  input  wire logic       cmp2_out,
  input  wire logic       ext_int_pin,
  input  wire logic       sync_tick,
  input  wire logic       comparator_sync_en,
  // Port latch values for unsteered pins
  input  wire logic [3:0] port_out,
  // Pins, index 0..3 = A..D
  output logic      [3:0] pwm_out,
  output logic      [3:0] pwm_oe,
  output logic      [3:0] steer_active,
  output logic      [1:0] chan1_timebase,
  output logic            irq
);
  import eps_pkg::*;

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  // Every flop of the block lives in this one record
  typedef struct packed {
    logic [7:0]    tmrsel;
    logic [7:0]    asd;
    logic [7:0]    rdly;
    logic [7:0]    steer_sh;
    logic [7:0]    steer_eff;
    logic [7:0]    chcon;
    logic [1:0]    irq_st;
    logic [1:0]    irq_msk;
    logic [7:0]    rdata;
    eps_state_type st;
    logic [1:0]    qcnt;
    logic [6:0]    dcnt;
    logic          dly_out;
    logic          prev_raw;
    logic [1:0]    c1s;
    logic [1:0]    c2s;
    logic [1:0]    ints;
    logic          cmp_lat1;
    logic          cmp_lat2;
    logic [3:0]    pout;
    logic [3:0]    poe;
    logic [3:0]    sact;
    logic [1:0]    tb1;
    logic          irq;
  } eps_regs_type;

  eps_regs_type r, n;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Pin level driven in the shutdown state for a given safe code
  function automatic logic safe_lvl(input logic [1:0] code);
    safe_lvl = (code == SAFE_HIGH);
  endfunction

  // Source decode of the shutdown select field
  function automatic logic src_hit(input logic [2:0] sel, input logic c1,
                                   input logic c2, input logic pin_low);
    src_hit = (sel[0] & c1) | (sel[1] & c2) | (sel[2] & pin_low);
  endfunction

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  // Selected shutdown source active this cycle
  logic cause;
  // Last master clock of an instruction cycle
  logic icyc;
  logic steer_ok;
  logic wave;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    // Pin inputs pass two flip-flops
    n.c1s  = {r.c1s[0], cmp1_out};
    n.c2s  = {r.c2s[0], cmp2_out};
    n.ints = {r.ints[0], ext_int_pin};
    n.qcnt = r.qcnt + 2'h1;
    icyc   = (r.qcnt == QCNT_LAST);
    // Comparator levels, optionally latched on the sync tick
    if (!comparator_sync_en || sync_tick) begin
      n.cmp_lat1 = r.c1s[1];
      n.cmp_lat2 = r.c2s[1];
    end
    cause = src_hit(r.asd[6:4], n.cmp_lat1, n.cmp_lat2, ~r.ints[1]);
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_TMRSEL: n.tmrsel = reg_wdata;
        ADDR_ASD:    n.asd = reg_wdata;
        ADDR_RDLY:   n.rdly = reg_wdata;
        ADDR_STEER:  n.steer_sh = reg_wdata & STEER_MASK;
        ADDR_CHCON:  n.chcon = reg_wdata;
        ADDR_IRQMSK: n.irq_msk = reg_wdata[1:0];
        default:     n.irq_st = r.irq_st;
      endcase
    end
    // Shutdown machine; hardware set wins over software clear
    // Status bit and state always move together, so the status
    // never reads set while the pins still run
    case (r.st)
      EPS_RUN: begin
        if (cause) begin
          n.st = EPS_SHUT;
          n.asd[7] = 1'b1;
          n.irq_st[0] = 1'b1;
        end else if (n.asd[7]) begin
          // Software forced shutdown
          n.st = EPS_SHUT;
        end
      end
      EPS_SHUT: begin
        if (cause) begin
          n.asd[7] = 1'b1;
        end else if (r.rdly[7]) begin
          n.asd[7] = 1'b0;
          n.st = EPS_RUN;
          n.irq_st[1] = 1'b1;
        end else if (!n.asd[7]) begin
          n.st = EPS_RUN;
          n.irq_st[1] = 1'b1;
        end
      end
      default: n.st = EPS_RUN;
    endcase
    // Active edge delay in instruction cycles
    // Falling edges pass at once; only the rising edge waits
    // The free quarter counter gives up to one cycle of jitter
    n.prev_raw = pwm_raw;
    if (!pwm_raw) begin
      n.dly_out = 1'b0;
      n.dcnt = 7'h00;
    end else if (!r.prev_raw) begin
      n.dcnt = r.rdly[6:0];
      n.dly_out = (r.rdly[6:0] == 7'h00);
    end else if (!r.dly_out && icyc) begin
      if (r.dcnt <= 7'h01) begin
        n.dly_out = 1'b1;
      end
      n.dcnt = r.dcnt - 7'h01;
    end
    // Steering update point
    // Shadow copy is taken whole so pins never see a half change
    if (r.steer_sh[4] ? period_start : icyc) begin
      n.steer_eff = r.steer_sh;
    end
    // Steering only in PWM mode with single output configuration
    steer_ok = (r.chcon[3:2] == MODE_PWM) && (r.chcon[7:6] == CFG_SINGLE);
    // Delayed waveform feeds every steered pin
    wave = r.dly_out;
    // Per pin: steered waveform, safe state, or port latch
    for (int i = 0; i < 4; i++) begin
      n.sact[i] = steer_ok & r.steer_eff[i];
      if (n.sact[i]) begin
        // A/C use bit 1, B/D use bit 0
        n.pout[i] = wave ^ r.chcon[(i % 2 == 0) ? 1 : 0];
        n.poe[i] = 1'b1;
        if (r.st == EPS_SHUT) begin
          n.pout[i] = safe_lvl((i % 2 == 0) ? r.asd[3:2] : r.asd[1:0]);
          n.poe[i] = ~((i % 2 == 0) ? r.asd[3] : r.asd[1]);
        end
      end else begin
        n.pout[i] = port_out[i];
        n.poe[i] = 1'b1;
      end
    end
    // Channel 1 timebase select output; reserved code falls back to first
    n.tb1 = (r.tmrsel[1:0] == QCNT_LAST) ? TB_FIRST : r.tmrsel[1:0];
    // Read data, one cycle later; status read clears
    n.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_TMRSEL: n.rdata = r.tmrsel;
        ADDR_ASD:    n.rdata = r.asd;
        ADDR_RDLY:   n.rdata = r.rdly;
        ADDR_STEER:  n.rdata = r.steer_sh;
        ADDR_CHCON:  n.rdata = r.chcon;
        ADDR_IRQST: begin
          n.rdata = {6'h00, r.irq_st};
          n.irq_st = n.irq_st & ~r.irq_st;
          // Events in the same cycle as the read win over its clear
          if (r.st == EPS_RUN && cause) n.irq_st[0] = 1'b1;
          if (r.st == EPS_SHUT && n.st == EPS_RUN) n.irq_st[1] = 1'b1;
        end
        ADDR_IRQMSK: n.rdata = {6'h00, r.irq_msk};
        default:     n.rdata = 8'h00;
      endcase
    end
    // Level interrupt from unmasked sticky status
    n.irq = |(n.irq_st & n.irq_msk);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '{tmrsel: RST_TMRSEL, asd: RST_ASD, rdly: RST_RDLY, steer_sh: RST_STEER,
             steer_eff: RST_STEER, chcon: RST_CHCON, st: EPS_RUN, ints: 2'h3,
             default: '0};
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign reg_rdata      = r.rdata;
  assign pwm_out        = r.pout;
  assign pwm_oe         = r.poe;
  assign steer_active   = r.sact;
  assign chan1_timebase = r.tb1;
  assign irq            = r.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  shut_sets_flag_a: assert property (r.st == EPS_RUN && cause |=> r.asd[7] && r.st == EPS_SHUT)
    else $error("shutdown not entered");
  held_while_cause_a: assert property (r.st == EPS_SHUT && cause |=> r.asd[7])
    else $error("status cleared under active cause");
  auto_restart_a: assert property (r.st == EPS_SHUT && !cause && r.rdly[7] |=> !r.asd[7])
    else $error("auto restart failed");
  manual_hold_a: assert property (r.st == EPS_SHUT && !r.rdly[7]
                                  && !(reg_wr && reg_addr == ADDR_ASD && !reg_wdata[7])
                                  |=> r.st == EPS_SHUT)
    else $error("left shutdown without clear");
  steer_top_zero_a: assert property (r.steer_sh[7:5] == 3'h0)
    else $error("steering top bits set");
  steer_gate_a: assert property (!steer_ok |=> r.sact == 4'h0)
    else $error("steering outside single pwm");
  status_flag_a: assert property (r.asd[7] |-> r.st == EPS_SHUT)
    else $error("status set while running");
  safe_low_a: assert property (r.st == EPS_SHUT && r.sact[0] && r.asd[3:2] == SAFE_LOW
                               && n.sact[0] |=> !r.pout[0] && r.poe[0])
    else $error("pin A safe level wrong");
  safe_tri_a: assert property (r.st == EPS_SHUT && r.asd[1] && n.sact[1] |=> !r.poe[1])
    else $error("pin B not released");
  delay_zero_a: assert property (pwm_raw && !r.prev_raw && r.rdly[6:0] == 7'h00 |=> r.dly_out)
    else $error("zero delay not immediate");

  // Steps of a shutdown and of an automatic restart
  sequence cause_in_run_s;
    r.st == EPS_RUN && cause;
  endsequence
  sequence shut_entered_s;
    r.st == EPS_SHUT && r.asd[7];
  endsequence
  sequence quiet_auto_s;
    r.st == EPS_SHUT && !cause && r.rdly[7];
  endsequence

  // Cause in run leads to shutdown with status set
  entry_seq_a: assert property (cause_in_run_s |=> shut_entered_s)
    else $error("shutdown entry broken");
  // Automatic restart flags its event
  restart_flag_a: assert property (quiet_auto_s |=> r.st == EPS_RUN && r.irq_st[1])
    else $error("restart event lost");
  // Unmasked shutdown entry raises the interrupt
  irq_entry_a: assert property (cause_in_run_s ##0 r.irq_msk[0]
                                && !(reg_wr && reg_addr == ADDR_IRQMSK) |=> r.irq)
    else $error("interrupt not raised");
  // Channel 1 timebase follows its field
  timebase_a: assert property (r.tmrsel[1:0] != 2'h3 |=> r.tb1 == $past(r.tmrsel[1:0]))
    else $error("timebase select wrong");
  // Reserved timebase code falls back to the first timer
  tb_reserved_a: assert property (&r.tmrsel[1:0] |=> r.tb1 == TB_FIRST)
    else $error("reserved timebase used");
  // Synchronous steering waits for the period start
  steer_sync_a: assert property (r.steer_sh[4] && !period_start
                                 |=> $stable(r.steer_eff))
    else $error("steering changed mid period");
  // Immediate steering takes the shadow at the cycle boundary
  steer_async_a: assert property (!r.steer_sh[4] && icyc
                                  |=> r.steer_eff == $past(r.steer_sh))
    else $error("steering not updated");
  // Pin A carries the delayed wave with the A/C polarity
  polarity_ac_a: assert property (steer_ok && r.steer_eff[0] && r.st == EPS_RUN
                                  |=> r.pout[0] == ($past(r.dly_out) ^ $past(r.chcon[1])))
    else $error("pin A polarity wrong");
  // Without steering the pins show the port latch
  port_pass_a: assert property (!steer_ok |=> r.pout == $past(port_out))
    else $error("port latch not passed");
  // Status read returns the shutdown register
  status_read_a: assert property (reg_rd && reg_addr == ADDR_ASD |=> r.rdata == $past(r.asd))
    else $error("status read wrong");
  // A non-zero delay holds the rising edge back
  delay_hold_a: assert property (pwm_raw && !r.prev_raw && r.rdly[6:0] != 7'h00
                                 |=> !r.dly_out)
    else $error("rising edge not delayed");
  // Source code zero never causes a shutdown
  src_off_a: assert property (r.asd[6:4] == 3'h0 |-> !cause)
    else $error("disabled source acted");
endmodule
`default_nettype wire

// [core/eps_pkg.sv]
// Package for the enhanced PWM shutdown and steering block
package eps_pkg;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [2:0] ADDR_TMRSEL = 3'h0;
  localparam logic [2:0] ADDR_ASD    = 3'h1;
  localparam logic [2:0] ADDR_RDLY   = 3'h2;
  localparam logic [2:0] ADDR_STEER  = 3'h3;
  localparam logic [2:0] ADDR_CHCON  = 3'h4;
  localparam logic [2:0] ADDR_IRQST  = 3'h5;
  localparam logic [2:0] ADDR_IRQMSK = 3'h6;
  // ----------------------------------------
  // Reset values and steering write mask
  // ----------------------------------------
  localparam logic [7:0] RST_TMRSEL = 8'h00;
  localparam logic [7:0] RST_ASD    = 8'h00;
  localparam logic [7:0] RST_RDLY   = 8'h00;
  localparam logic [7:0] RST_STEER  = 8'h01;
  localparam logic [7:0] RST_CHCON  = 8'h00;
  localparam logic [7:0] STEER_MASK = 8'h1F;
  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [1:0] TB_FIRST  = 2'h0;
  localparam logic [1:0] TB_SECOND = 2'h1;
  localparam logic [1:0] TB_THIRD  = 2'h2;
  localparam logic [1:0] MODE_PWM  = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] SAFE_LOW  = 2'h0;
  localparam logic [1:0] SAFE_HIGH = 2'h1;
  localparam logic [1:0] QCNT_LAST = 2'h3;
  // Instruction cycle = four master clocks
  localparam int         OSC_PER_ICYC = 4;
  typedef enum logic [1:0] {
    EPS_RUN  = 2'b01,
    EPS_SHUT = 2'b10
  } eps_state_type;
endpackage
